// [timer_chan_pkg.sv]
package timer_chan_pkg;
   // channel layout
   localparam int NUM_CH = 8;
   localparam int FIRST_CH = 2;
   localparam int CH7 = 7;
   // register indices (byte address = 4 * index)
   localparam logic [5:0] IDX_IO_SELECT = 6'h00;
   localparam logic [5:0] IDX_OVR_MASK = 6'h02;
   localparam logic [5:0] IDX_OVR_DATA = 6'h03;
   localparam logic [5:0] IDX_COUNTER = 6'h04;
   localparam logic [5:0] IDX_ACT_HI = 6'h08;
   localparam logic [5:0] IDX_ACT_LO = 6'h09;
   localparam logic [5:0] IDX_EDGE_HI = 6'h0A;
   localparam logic [5:0] IDX_EDGE_LO = 6'h0B;
   localparam logic [5:0] IDX_IRQ_EN = 6'h0C;
   localparam logic [5:0] IDX_FLAG = 6'h0E;
   localparam logic [2:0] IDX_VALUE_TOP = 3'h2;
   // reset values and counter step
   localparam logic [7:0] REG8_RST = 8'h00;
   localparam logic [15:0] REG16_RST = 16'h0000;
   localparam logic [15:0] COUNT_STEP = 16'h0001;
   // compare action codes {mode, level}
   localparam logic [1:0] ACT_OFF = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;
   // capture edge codes {high, low}
   localparam logic [1:0] EDGE_OFF = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_ANY = 2'h3;

   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } avl_req_t;
endpackage

// [capture_edge.sv]
`timescale 1ns/1ps
module capture_edge (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // synchronised pin level and edge selection
   input wire logic level,
   input wire logic [1:0] edge_sel,
   // capture event
   output logic capture
);
   import timer_chan_pkg::*;
   logic prev_reg;
   logic rise;
   logic fall;

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         prev_reg <= 1'b0;
      else
         prev_reg <= level;
   end

   assign rise = level & ~prev_reg;
   assign fall = ~level & prev_reg;

   always_comb
   begin
      case (edge_sel)
         EDGE_RISE: capture = rise;
         EDGE_FALL: capture = fall;
         EDGE_ANY: capture = rise | fall;
         default: capture = 1'b0;
      endcase
   end
endmodule

// [compare_action.sv]
`timescale 1ns/1ps
module compare_action (
   // action select {mode, level}
   input wire logic [1:0] action,
   // compare events
   input wire logic own_fire,
   input wire logic ovr_fire,
   input wire logic ovr_data,
   // pin level
   input wire logic cur_level,
   output logic next_level
);
   import timer_chan_pkg::*;

   always_comb
   begin
      next_level = cur_level;
      if (ovr_fire)
         next_level = ovr_data;
      else if (own_fire)
      begin
         // own compare acts only without a channel-7 override; in a tie only the override acts
         case (action)
            ACT_TOGGLE: next_level = ~cur_level;
            ACT_CLEAR: next_level = 1'b0;
            ACT_SET: next_level = 1'b1;
            default: next_level = cur_level;
         endcase
      end
   end
endmodule

// [timer_channel_action_and_edge_control.sv]
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
// Function
// - mode 0 level 0: compare leaves the pin untouched
// - mode 0 level 1: compare toggles the output line
// - mode 1 level 0: compare drives the output line low
// - mode 1 level 1: compare drives the output line high
// - nonzero mode or level makes the pin an output
// - with mask set, both channel-7 and own compares change the pin
// - mask bit 7 set: channel-7 compare drives pin from data bit 7
// - two-bit edge code; 00 disables, 01 captures rising edges
// - code 10 captures falling edges, 11 captures both edges
// - edge fields packed as bit pairs across two 8-bit registers
// - interrupt enable bits match flag bits; clear enable blocks request
// - interrupt requested while any enabled flag is set
// - channel-7 compare overrides channels 6..2 where mask bit set
// - selected capture edge latches counter into value register of a channel with io select bit clear
// - capture event with io select bit clear, or compare event, sets the channel flag
module timer_channel_action_and_edge_control (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // register bus
   input wire timer_chan_pkg::avl_req_t avl_req,
   output logic [31:0] avl_readdata,
   output logic avl_waitrequest,
   // channel pins
   input wire logic [7:0] channel_pin_in,
   output logic [7:0] channel_pin_out,
   output logic [7:0] channel_pin_oe,
   // interrupt request
   output logic irq_req
);
   import timer_chan_pkg::*;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   logic [7:0] pin_meta_reg;
   logic [7:0] pin_sync_reg;
   logic [15:0] counter_reg;
   logic [15:0] value_reg [NUM_CH];
   logic [7:0] io_select_reg;
   logic [7:0] ch7_override_mask;
   logic [7:0] ch7_override_data;
   logic [15:0] action_reg;
   logic [15:0] edge_reg;
   logic [7:0] channel_irq_enables;
   logic [7:0] channel_flag_reg;
   logic [7:0] flag_next;
   logic [7:0] flag_set;
   logic [7:0] flag_clr;
   logic [7:0] ch_match;
   logic [7:0] ch_capture;
   logic [7:0] next_level;
   logic [7:0] out_reg;
   logic [7:0] oe_reg;
   logic wait_reg;
   logic irq_reg;
   logic [31:0] readdata_reg;
   logic [31:0] rd_word;
   logic [5:0] idx;
   logic wr_go;
   logic [1:0] be_lo;

   function automatic logic is_value(input logic [5:0] index);
      return index[5:3] == IDX_VALUE_TOP;
   endfunction

   assign idx = avl_req.address[7:2];
   assign be_lo = avl_req.byteenable[1:0];
   // write takes effect at the edge where waitrequest is seen low
   assign wr_go = avl_req.write && !wait_reg;

   // pin synchroniser
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         pin_meta_reg <= REG8_RST;
         pin_sync_reg <= REG8_RST;
      end
      else
      begin
         pin_meta_reg <= channel_pin_in;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // free-running counter, one count per clock
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         counter_reg <= REG16_RST;
      else
         counter_reg <= counter_reg + COUNT_STEP;
   end

   // bus handshake: one wait state, then a one-cycle answer
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         wait_reg <= 1'b1;
      else if (!wait_reg)
         wait_reg <= 1'b1;
      else if (avl_req.read || avl_req.write)
         wait_reg <= 1'b0;
   end

   always_comb
   begin
      rd_word = 32'h00000000;
      case (idx)
         IDX_IO_SELECT: rd_word[7:0] = io_select_reg;
         IDX_OVR_MASK: rd_word[7:0] = ch7_override_mask;
         IDX_OVR_DATA: rd_word[7:0] = ch7_override_data;
         IDX_COUNTER: rd_word[15:0] = counter_reg;
         IDX_ACT_HI: rd_word[7:0] = action_reg[15:8];
         IDX_ACT_LO: rd_word[7:0] = action_reg[7:0];
         IDX_EDGE_HI: rd_word[7:0] = edge_reg[15:8];
         IDX_EDGE_LO: rd_word[7:0] = edge_reg[7:0];
         IDX_IRQ_EN: rd_word[7:0] = channel_irq_enables;
         IDX_FLAG: rd_word[7:0] = channel_flag_reg;
         default:
         begin
            if (is_value(idx))
               rd_word[15:0] = value_reg[idx[2:0]];
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         readdata_reg <= 32'h00000000;
      else if (avl_req.read && wait_reg)
         readdata_reg <= rd_word;
   end

   // configuration registers
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         io_select_reg <= REG8_RST;
         ch7_override_mask <= REG8_RST;
         ch7_override_data <= REG8_RST;
         channel_irq_enables <= REG8_RST;
      end
      else if (wr_go && avl_req.byteenable[0])
      begin
         case (idx)
            IDX_IO_SELECT: io_select_reg <= avl_req.writedata[7:0];
            IDX_OVR_MASK: ch7_override_mask <= avl_req.writedata[7:0];
            IDX_OVR_DATA: ch7_override_data <= avl_req.writedata[7:0];
            IDX_IRQ_EN: channel_irq_enables <= avl_req.writedata[7:0];
            default: ;
         endcase
      end
   end

   // action and edge fields, two 8-bit halves each
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         action_reg <= REG16_RST;
         edge_reg <= REG16_RST;
      end
      else if (wr_go && avl_req.byteenable[0])
      begin
         case (idx)
            IDX_ACT_HI: action_reg[15:8] <= avl_req.writedata[7:0];
            IDX_ACT_LO: action_reg[7:0] <= avl_req.writedata[7:0];
            IDX_EDGE_HI: edge_reg[15:8] <= avl_req.writedata[7:0];
            IDX_EDGE_LO: edge_reg[7:0] <= avl_req.writedata[7:0];
            default: ;
         endcase
      end
   end

   // per-channel compare, capture and value registers
   for (genvar i = 0; i < NUM_CH; i++)
   begin : g_ch
      if (i >= FIRST_CH)
      begin : g_live
         assign ch_match[i] = io_select_reg[i] && (counter_reg == value_reg[i]);
         capture_edge u_edge (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .level(pin_sync_reg[i]),
            .edge_sel(edge_reg[2*i+1 -: 2]),
            .capture(ch_capture[i])
         );
         compare_action u_act (
            .action(action_reg[2*i+1 -: 2]),
            .own_fire(ch_match[i] && !(i == CH7 && ch7_override_mask[CH7])),
            .ovr_fire(ch_match[CH7] && ch7_override_mask[i]),
            .ovr_data(ch7_override_data[i]),
            .cur_level(out_reg[i]),
            .next_level(next_level[i])
         );
         always_ff @(posedge sys_clk)
         begin
            if (!resetn)
               value_reg[i] <= REG16_RST;
            else if (ch_capture[i] && !io_select_reg[i])
               value_reg[i] <= counter_reg;
            else if (wr_go && is_value(idx) && idx[2:0] == i && io_select_reg[i])
            begin
               if (be_lo[0])
                  value_reg[i][7:0] <= avl_req.writedata[7:0];
               if (be_lo[1])
                  value_reg[i][15:8] <= avl_req.writedata[15:8];
            end
         end
      end
      else
      begin : g_absent
         assign ch_match[i] = 1'b0;
         assign ch_capture[i] = 1'b0;
         assign next_level[i] = 1'b0;
         always_ff @(posedge sys_clk)
         begin
            value_reg[i] <= REG16_RST;
         end
      end
   end

   // pin drive
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         out_reg <= REG8_RST;
         oe_reg <= REG8_RST;
      end
      else
      begin
         out_reg <= next_level;
         for (int i = 0; i < NUM_CH; i++)
         begin
            if (i >= FIRST_CH)
               oe_reg[i] <= (|action_reg[2*i+1 -: 2])
                  || (ch7_override_mask[i] && io_select_reg[i]);
            else
               oe_reg[i] <= 1'b0;
         end
      end
   end

   // channel flags, a set in the clearing cycle wins
   assign flag_set = ch_match | (ch_capture & ~io_select_reg);
   assign flag_clr = (wr_go && idx == IDX_FLAG && avl_req.byteenable[0])
      ? avl_req.writedata[7:0] : REG8_RST;
   assign flag_next = (channel_flag_reg & ~flag_clr) | flag_set;

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         channel_flag_reg <= REG8_RST;
      else
         channel_flag_reg <= flag_next;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         irq_reg <= 1'b0;
      else
         irq_reg <= |(channel_flag_reg & channel_irq_enables);
   end

   assign avl_readdata = readdata_reg;
   assign avl_waitrequest = wait_reg;
   assign channel_pin_out = out_reg;
   assign channel_pin_oe = oe_reg;
   assign irq_req = irq_reg;

   toggle_out_a: assert property (
      ch_match[3] && !ch7_override_mask[3] && action_reg[7:6] == ACT_TOGGLE
      |=> channel_pin_out[3] != $past(channel_pin_out[3]))
      else $error("toggle action did not invert the pin");

   clear_out_a: assert property (
      ch_match[4] && !ch7_override_mask[4] && action_reg[9:8] == ACT_CLEAR
      |=> !channel_pin_out[4])
      else $error("clear action did not drive the pin low");

   set_out_a: assert property (
      ch_match[5] && !ch7_override_mask[5] && action_reg[11:10] == ACT_SET
      |=> channel_pin_out[5])
      else $error("set action did not drive the pin high");

   hold_out_a: assert property (
      !(ch_match[7] && ch7_override_mask[2]) && action_reg[5:4] == ACT_OFF
      |=> $stable(channel_pin_out[2]))
      else $error("disconnected channel changed its pin");

   pin_enable_a: assert property (
      action_reg[13:12] != ACT_OFF |=> channel_pin_oe[6])
      else $error("active action did not enable the pin");

   override_wins_a: assert property (
      ch_match[7] && ch7_override_mask[7] && ch7_override_mask[2]
      |=> channel_pin_out[7] == $past(ch7_override_data[7])
      && channel_pin_out[2] == $past(ch7_override_data[2]))
      else $error("channel-7 override data not driven");

   rise_capture_a: assert property (
      !io_select_reg[6] && edge_reg[13:12] == EDGE_RISE && $rose(pin_sync_reg[6])
      |=> value_reg[6] == $past(counter_reg) && channel_flag_reg[6])
      else $error("rising edge not captured");

   capture_latch_a: assert property (
      ch_capture[4] && !io_select_reg[4] |=> value_reg[4] == $past(counter_reg))
      else $error("capture did not latch the counter");

   flag_set_a: assert property (
      flag_set[5] |=> channel_flag_reg[5])
      else $error("event did not set the channel flag");

   irq_gate_a: assert property (
      |(channel_flag_reg & channel_irq_enables) |=> irq_req ##0
      $past(|(channel_flag_reg & channel_irq_enables)) == irq_req)
      else $error("interrupt request not tied to enabled flags");

   irq_block_a: assert property (
      !(|(channel_flag_reg & channel_irq_enables)) |=> !irq_req)
      else $error("interrupt request without an enabled flag");

   bus_answer_a: assert property (
      (avl_req.read || avl_req.write) && avl_waitrequest |=> !avl_waitrequest ##1 avl_waitrequest)
      else $error("bus answer not after one wait state");
endmodule

// [pin_partner.sv]
`timescale 1ns/1ps
module pin_partner (
   // clock
   input wire logic sys_clk,
   // pin drive from the timer
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   // level from the outside source
   input wire logic [7:0] ext_level,
   // resolved wire level
   output logic [7:0] pin_in
);
   logic [1:0] float_reg = 2'h0;
   // absent channels float: a changing pattern keeps a settled value from passing
   always_ff @(posedge sys_clk)
   begin
      float_reg <= ~float_reg;
   end
   // device drive where enabled, outside source elsewhere
   assign pin_in = {(pin_oe[7:2] & pin_out[7:2]) | (~pin_oe[7:2] & ext_level[7:2]), float_reg};
endmodule

// [timer_channel_action_and_edge_control_tb.sv]
`timescale 1ns/1ps
module timer_channel_action_and_edge_control_tb;
   import timer_chan_pkg::*;
   logic sys_clk;
   logic resetn;
   avl_req_t avl_req;
   logic [31:0] avl_readdata;
   logic avl_waitrequest;
   logic [7:0] channel_pin_in;
   logic [7:0] channel_pin_out;
   logic [7:0] channel_pin_oe;
   logic [7:0] ext_level;
   logic irq_req;
   logic [63:0] rd_q[$];
   logic [63:0] note;
   logic [31:0] q;
   logic [31:0] c;
   logic [7:0] pin_exp;
   logic [7:0] oe_exp;
   logic [7:0] r;
   int err_total = 0;
   int comparisons = 0;
   int seed = 32'h008B;
   int i;

   timer_channel_action_and_edge_control dut (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .avl_req(avl_req),
      .avl_readdata(avl_readdata),
      .avl_waitrequest(avl_waitrequest),
      .channel_pin_in(channel_pin_in),
      .channel_pin_out(channel_pin_out),
      .channel_pin_oe(channel_pin_oe),
      .irq_req(irq_req)
   );

   pin_partner partner (
      .sys_clk(sys_clk),
      .pin_out(channel_pin_out),
      .pin_oe(channel_pin_oe),
      .ext_level(ext_level),
      .pin_in(channel_pin_in)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task end_of_test;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // one bus access; a read notes its expected data under a mask
   task bus(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      @(posedge sys_clk);
      if (rd)
         rd_q.push_back({m, d});
      avl_req <= '{read: rd, write: !rd, address: a, byteenable: 4'hF,
                   writedata: rd ? 32'h0 : d};
      // only the watchdog ends a wait that never gets its answer
      do
         @(posedge sys_clk);
      while (avl_waitrequest !== 1'b0);
      q = avl_readdata;
      avl_req <= '0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b0, a, d, 32'h0);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b1, a, e, 32'hFFFFFFFF);
   endtask

   // aim the value registers of ch2..ch7 ahead of the counter, ch6 ten counts early
   task cmp_pass(input logic mid6);
      int ch;
      bus(1'b1, 8'h10, 32'h0, 32'hFFFF0000);
      c = q + 100;
      for (ch = 2; ch < 8; ch++)
         wr(8'h40 + 8'(4 * ch), (ch == 6) ? c - 10 : c);
      bus(1'b1, 8'h10, 32'h0, 32'hFFFF0000);
      repeat (int'(c - 5 - q)) @(posedge sys_clk);
      chk("pin_out ch6 early", {31'h0, mid6}, {31'h0, channel_pin_out[6]});
      repeat (20) @(posedge sys_clk);
      chk("pin_out", {24'h0, pin_exp}, {24'h0, channel_pin_out});
      chk("pin_oe", {24'h0, oe_exp}, {24'h0, channel_pin_oe});
   endtask

   always @(posedge sys_clk)
   begin
      if (avl_req.read && avl_waitrequest === 1'b0 && rd_q.size() > 0)
      begin
         note = rd_q.pop_front();
         chk("readdata", note[31:0] & note[63:32], avl_readdata & note[63:32]);
      end
   end

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      end_of_test;
   end

   initial
   begin
      resetn = 1'b0;
      avl_req = '0;
      ext_level = 8'h00;
      pin_exp = 8'h00;
      oe_exp = 8'h00;
      repeat (16) @(posedge sys_clk);
      resetn <= 1'b1;
      for (i = 0; i < 5; i++)
         rd(8'h20 + 8'(4 * i), 32'h0);
      for (i = 0; i < 5; i++)
      begin
         r = 8'($random(seed));
         if (i == 4)
            r = r & 8'hFC;
         wr(8'h20 + 8'(4 * i), {24'h0, r});
         rd(8'h20 + 8'(4 * i), {24'h0, r});
      end
      wr(8'hFC, 32'hFF);
      rd(8'hFC, 32'h0);
      // capture: ch3 rise, ch4 fall, ch5 any, ch6 rise, ch7 fall, ch2 off
      wr(8'h30, 32'h0);
      wr(8'h20, 32'h0);
      wr(8'h24, 32'h0);
      wr(8'h28, 32'h9E);
      wr(8'h2C, 32'h40);
      bus(1'b1, 8'h10, 32'h0, 32'hFFFF0000);
      c = q;
      ext_level <= 8'hFC;
      repeat (10) @(posedge sys_clk);
      rd(8'h38, 32'h68);
      bus(1'b1, 8'h4C, 32'h0, 32'hFFFF0000);
      chk("capture value", 32'h1, 32'(q > c && q < c + 20));
      wr(8'h38, 32'hFF);
      ext_level <= 8'h00;
      repeat (10) @(posedge sys_clk);
      rd(8'h38, 32'hB0);
      wr(8'h38, 32'hFF);
      // compare actions: ch2 off, ch3 toggle, ch4 clear, ch5 set
      wr(8'h00, 32'h3C);
      wr(8'h08, 32'h0);
      wr(8'h24, 32'h40);
      wr(8'h20, 32'h0E);
      pin_exp = 8'h28;
      oe_exp = 8'h38;
      cmp_pass(1'b0);
      rd(8'h38, 32'h3C);
      chk("irq_req", 32'h0, {31'h0, irq_req});
      wr(8'h30, 32'h08);
      repeat (3) @(posedge sys_clk);
      chk("irq_req", 32'h1, {31'h0, irq_req});
      wr(8'h38, 32'h08);
      repeat (3) @(posedge sys_clk);
      chk("irq_req", 32'h0, {31'h0, irq_req});
      rd(8'h38, 32'h34);
      pin_exp = 8'h20;
      cmp_pass(1'b0);
      // override: mask ch7, ch6, ch2; ch7 action clear, ch6 set
      wr(8'h00, 32'hFC);
      wr(8'h20, 32'hBE);
      wr(8'h08, 32'hC4);
      wr(8'h0C, 32'h84);
      pin_exp = 8'hAC;
      oe_exp = 8'hFC;
      cmp_pass(1'b1);
      end_of_test;
   end
endmodule
